/* File: spr_pkg.sv */
// Constants shared by the priority regeneration and learn-discard bank
package spr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_TBL0 = 14'h1855;
    localparam logic [13:0] IDX_TBL1 = 14'h1856;
    localparam logic [13:0] IDX_TBL2 = 14'h1857;
    localparam logic [13:0] IDX_CNT0 = 14'h1858;
    localparam logic [13:0] IDX_CNT1 = 14'h1859;
    localparam logic [13:0] IDX_CNT2 = 14'h185a;
    localparam logic [13:0] IDX_GMASK = 14'h1880;
    localparam logic [13:0] IDX_PEND = 14'h1881;
    localparam logic [13:0] IDX_EVMASK = 14'h1882;

    // Port and table geometry
    localparam int NUM_PORTS = 3;
    localparam int PRIO_W = 3;
    localparam int NUM_PRIOS = 8;
    localparam int TBL_W = 24;
    localparam int CNT_W = 32;
    localparam int QSEL_W = 2;

    // Identity mapping: entry n holds n
    localparam logic [23:0] TBL_RESET = 24'hfac688;

    // Counter values
    localparam logic [31:0] CNT_RESET = 32'h00000000;
    localparam logic [31:0] CNT_MAX = 32'hffffffff;

    // Global mask bit position and reset value
    localparam int GMASK_BIT = 0;
    localparam logic GMASK_RESET = 1'b1;

    // Pending event layout: one bit per port discard, one engine event
    localparam int EV_W = 4;
    localparam int EV_DISCARD0 = 0;
    localparam int EV_ENGINE = 3;
    localparam logic [3:0] PEND_RESET = 4'h0;
    localparam logic [3:0] EVMASK_RESET = 4'h0;

    // Frame port code that names no port
    localparam logic [1:0] PORT_NONE = 2'h3;

    // Bus answer idle values
    localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage : spr_pkg

/* File: spr_regen_learn.sv */
// Priority regeneration tables, learn-discard counters and interrupt gating
//
// Function
// - Frame priority maps through port table to queue
// - Eight 3-bit entries, entry n at 3n+2:3n
// - Tables reset to identity mapping
// - Three tables, ports 0..2, consecutive indices
// - Count unlearned or displaced addresses per port
// - Counters reset to zero, cleared by read
// - Counters saturate at all ones
// - Global mask bit0 blocks interrupts, resets set
// - Clearing global mask releases pending interrupts
// - Global mask never touches pending status bits
module spr_regen_learn #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frame priority lookup request
    input wire logic frameValid,
    input wire logic [1:0] framePort,
    input wire logic [2:0] frameRxPrio,
    // Regenerated priority and chosen output queue
    output logic queueValid,
    output logic [2:0] regenPrio,
    output logic [1:0] queueSel,
    // Address table full: address not learned or displaced, per port
    input wire logic [2:0] learnDiscard,
    // Other engine interrupt source
    input wire logic engineEvent,
    // Level interrupt towards the system
    output logic irq
);

    // Complete state of the block
    // Reset state: identity tables, zero counts, global mask set
    typedef struct packed {
        logic [spr_pkg::NUM_PORTS-1:0][spr_pkg::TBL_W-1:0] tbl;
        logic [spr_pkg::NUM_PORTS-1:0][spr_pkg::CNT_W-1:0] cnt;
        logic gmask;
        logic [spr_pkg::EV_W-1:0] pend;
        logic [spr_pkg::EV_W-1:0] evMask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic queueValid;
        logic [spr_pkg::PRIO_W-1:0] regenPrio;
        logic [spr_pkg::QSEL_W-1:0] queueSel;
        logic irq;
    } spr_state_t;

    spr_state_t st;
    spr_state_t next_st;

    // Pick the entry for one received priority out of a table word
    // Unrolled over the eight entries; priority 0 sits at the bottom
    function automatic logic [2:0] spr_lookup(
        input logic [23:0] word,
        input logic [2:0] prio
    );
        logic [2:0] res;
        res = 3'h0;
        for (int n = 0; n < spr_pkg::NUM_PRIOS; n++)
        begin
            if (prio == 3'(n))
            begin
                res = word[n*spr_pkg::PRIO_W +: spr_pkg::PRIO_W];
            end
        end
        return res;
    endfunction

    // Saturating increment of a discard counter
    // Wrapping would make a full count read back as a small one
    function automatic logic [31:0] spr_sat_inc(
        input logic [31:0] value
    );
        logic [31:0] res;
        res = value;
        if (value != spr_pkg::CNT_MAX)
        begin
            res = value + 32'h00000001;
        end
        return res;
    endfunction

    // True when a qualified access names the given register index
    function automatic logic spr_hit(
        input logic strobe,
        input logic [13:0] idx,
        input logic [13:0] target
    );
        return strobe && (idx == target);
    endfunction

    // Bus decode signals
    logic [13:0] regIdx;
    logic aligned;
    logic commit;
    logic rdCommit;
    logic wrCommit;
    logic mapped;
    logic rdAligned;
    logic wrAligned;

    // Per-register strobes of a committed access
    logic [spr_pkg::NUM_PORTS-1:0] tblWrite;
    logic [spr_pkg::NUM_PORTS-1:0] cntClear;
    logic gmaskWrite;
    logic evMaskWrite;
    logic pendClear;

    // Frame lookup signals
    logic frameTaken;
    logic [spr_pkg::TBL_W-1:0] portTbl;
    logic [spr_pkg::PRIO_W-1:0] mappedPrio;
    logic [spr_pkg::QSEL_W-1:0] queuePick;

    // Word index and alignment of the bus address
    // Byte address bits 1:0 must be zero for a register hit
    always_comb
    begin
        regIdx = 14'(paddr[ADDR_W-1:2]);
        aligned = (paddr[1:0] == 2'h0);
    end

    // Access decided on the edge before pready is raised
    // Writes and clears land one cycle before the answer; a master
    // that holds its request until pready cannot tell the difference
    always_comb
    begin
        commit = psel && penable && !st.pready;
        rdCommit = commit && !pwrite;
        wrCommit = commit && pwrite;
        // Misaligned accesses select nothing behind the error answer
        rdAligned = rdCommit && aligned;
        wrAligned = wrCommit && aligned;
    end

    // Address map membership
    // Registers that answer without an error
    always_comb
    begin
        mapped = 1'b0;
        if (aligned)
        begin
            case (regIdx)
                spr_pkg::IDX_TBL0, spr_pkg::IDX_TBL1,
                spr_pkg::IDX_TBL2, spr_pkg::IDX_CNT0,
                spr_pkg::IDX_CNT1, spr_pkg::IDX_CNT2,
                spr_pkg::IDX_GMASK, spr_pkg::IDX_PEND,
                spr_pkg::IDX_EVMASK: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end

    // Strobes for the tables, counters and masks
    always_comb
    begin
        tblWrite = '0;
        cntClear = '0;
        for (int p = 0; p < spr_pkg::NUM_PORTS; p++)
        begin
            tblWrite[p] = spr_hit(wrAligned, regIdx,
                spr_pkg::IDX_TBL0 + 14'(p));
            cntClear[p] = spr_hit(rdAligned, regIdx,
                spr_pkg::IDX_CNT0 + 14'(p));
        end
        gmaskWrite = spr_hit(wrAligned, regIdx, spr_pkg::IDX_GMASK);
        evMaskWrite = spr_hit(wrAligned, regIdx, spr_pkg::IDX_EVMASK);
        pendClear = spr_hit(rdAligned, regIdx, spr_pkg::IDX_PEND);
    end

    // Table of the receiving port and its entry for the frame priority
    // A frame that names no port drops queueValid and leaves regenPrio and queueSel as they are
    always_comb
    begin
        case (framePort)
            2'h0: portTbl = st.tbl[0];
            2'h1: portTbl = st.tbl[1];
            2'h2: portTbl = st.tbl[2];
            default: portTbl = st.tbl[0];
        endcase
        frameTaken = frameValid && (framePort != spr_pkg::PORT_NONE);
        mappedPrio = spr_lookup(portTbl, frameRxPrio);
        // Four queues: regenerated priority pairs share a queue
        queuePick = mappedPrio[spr_pkg::PRIO_W-1 -: spr_pkg::QSEL_W];
    end

    // Next state of the whole block
    always_comb
    begin
        logic [spr_pkg::EV_W-1:0] events;
        logic [spr_pkg::EV_W-1:0] pendNext;
        logic [31:0] rd;
        logic [31:0] base;
        next_st = st;
        events = '0;
        pendNext = st.pend;
        rd = 32'h00000000;
        base = spr_pkg::CNT_RESET;

        // Bus answer: pready one cycle after access phase starts
        // Every transfer takes one wait state, mapped or not
        next_st.pready = commit;
        if (commit)
        begin
            next_st.pslverr = !mapped;
        end
        else
        begin
            next_st.pslverr = 1'b0;
        end

        // Read data, reserved bits read as zero
        // A counter read returns the count as it stood before its clear
        if (aligned)
        begin
            case (regIdx)
                spr_pkg::IDX_TBL0: rd = {8'h00, st.tbl[0]};
                spr_pkg::IDX_TBL1: rd = {8'h00, st.tbl[1]};
                spr_pkg::IDX_TBL2: rd = {8'h00, st.tbl[2]};
                spr_pkg::IDX_CNT0: rd = st.cnt[0];
                spr_pkg::IDX_CNT1: rd = st.cnt[1];
                spr_pkg::IDX_CNT2: rd = st.cnt[2];
                spr_pkg::IDX_GMASK: rd = {31'h0, st.gmask};
                spr_pkg::IDX_PEND: rd = {28'h0, st.pend};
                spr_pkg::IDX_EVMASK: rd = {28'h0, st.evMask};
                default: rd = 32'h00000000;
            endcase
        end
        if (rdCommit)
        begin
            next_st.prdata = rd;
        end

        // Table writes, entry n held at bits 3n+2:3n
        // Reserved bits 31:24 are dropped on write
        for (int p = 0; p < spr_pkg::NUM_PORTS; p++)
        begin
            if (tblWrite[p])
            begin
                next_st.tbl[p] = pwdata[spr_pkg::TBL_W-1:0];
            end
        end
        if (gmaskWrite)
        begin
            // Mask write leaves pending status alone
            next_st.gmask = pwdata[spr_pkg::GMASK_BIT];
        end
        if (evMaskWrite)
        begin
            next_st.evMask = pwdata[spr_pkg::EV_W-1:0];
        end

        // Discard counters: clear on read, then count, then saturate
        for (int p = 0; p < spr_pkg::NUM_PORTS; p++)
        begin
            base = st.cnt[p];
            if (cntClear[p])
            begin
                base = spr_pkg::CNT_RESET;
            end
            if (learnDiscard[p])
            begin
                // Event in the clearing cycle lands on the zeroed count
                next_st.cnt[p] = spr_sat_inc(base);
            end
            else
            begin
                next_st.cnt[p] = base;
            end
            events[spr_pkg::EV_DISCARD0 + p] = learnDiscard[p];
        end
        events[spr_pkg::EV_ENGINE] = engineEvent;

        // Pending bits clear on read; new events win over the clear
        // An event in the reading cycle stays pending for the next read
        if (pendClear)
        begin
            pendNext = '0;
        end
        next_st.pend = pendNext | events;

        // Interrupt: unmasked pending bit, gated by the global mask
        // Registered from the pending bits, so irq trails an event by two cycles
        next_st.irq = (|(st.pend & ~st.evMask))
            && !st.gmask;

        // Frame lookup through the receiving port's table
        next_st.queueValid = frameTaken;
        if (frameTaken)
        begin
            next_st.regenPrio = mappedPrio;
            next_st.queueSel = queuePick;
        end
    end

    // Single state register
    // Reset loads identity tables, zero counts and a set global mask
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int p = 0; p < spr_pkg::NUM_PORTS; p++)
            begin
                st.tbl[p] <= spr_pkg::TBL_RESET;
                st.cnt[p] <= spr_pkg::CNT_RESET;
            end
            st.gmask <= spr_pkg::GMASK_RESET;
            st.pend <= spr_pkg::PEND_RESET;
            st.evMask <= spr_pkg::EVMASK_RESET;
            st.prdata <= spr_pkg::RDATA_RESET;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.queueValid <= 1'b0;
            st.regenPrio <= 3'h0;
            st.queueSel <= 2'h0;
            st.irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    // No logic stands between the flip-flops and the pins
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign queueValid = st.queueValid;
    assign regenPrio = st.regenPrio;
    assign queueSel = st.queueSel;
    assign irq = st.irq;

endmodule // spr_regen_learn

/* File: spr_regen_learn_sva.sv */
// Port checker for the regeneration and learn-discard bank
module spr_regen_learn_sva #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frameValid,
    input wire logic [1:0] framePort,
    input wire logic [2:0] frameRxPrio,
    input wire logic queueValid,
    input wire logic [2:0] regenPrio,
    input wire logic [1:0] queueSel,
    input wire logic [2:0] learnDiscard,
    input wire logic engineEvent,
    input wire logic irq
);
    logic dec;
    logic tblHit;
    // Decide edge of a transfer and table address window
    assign dec = psel && penable && !pready;
    assign tblHit = paddr >= {spr_pkg::IDX_TBL0, 2'b00}
        && paddr <= {spr_pkg::IDX_TBL2, 2'b00} && paddr[1:0] == 2'h0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_qv;
        queueValid == $past(frameValid && framePort != spr_pkg::PORT_NONE);
    endproperty
    property p_qsel;
        queueValid |-> queueSel == regenPrio[2:1];
    endproperty
    property p_hold;
        !queueValid |-> $stable(regenPrio);
    endproperty
    property p_tblrd;
        pready && !pwrite && tblHit |-> prdata[31:24] == 8'h00 && !pslverr;
    endproperty
    property p_gm;
        dec && pwrite && paddr == {spr_pkg::IDX_GMASK, 2'b00} && pwdata[0]
        |=> ##1 !irq [*2];
    endproperty
    property p_rdy;
        dec |=> pready ##1 !pready;
    endproperty
    property p_err;
        pready && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    property p_qoff;
        frameValid && framePort == spr_pkg::PORT_NONE |=> !queueValid;
    endproperty
    a_qv: assert property (p_qv) else $error("queue valid timing");
    a_qsel: assert property (p_qsel) else $error("queue choice");
    a_hold: assert property (p_hold) else $error("priority moved");
    a_tblrd: assert property (p_tblrd) else $error("table read");
    a_gm: assert property (p_gm) else $error("mask leaked");
    a_rdy: assert property (p_rdy) else $error("ready pulse");
    a_err: assert property (p_err) else $error("misaligned ok");
    a_qoff: assert property (p_qoff) else $error("no-port frame");
    c_frame: cover property (frameValid ##1 queueValid);
    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
endmodule // spr_regen_learn_sva

bind spr_regen_learn spr_regen_learn_sva #(.ADDR_W(ADDR_W)) u_sva (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frameValid(frameValid),
    .framePort(framePort), .frameRxPrio(frameRxPrio),
    .queueValid(queueValid), .regenPrio(regenPrio), .queueSel(queueSel),
    .learnDiscard(learnDiscard), .engineEvent(engineEvent), .irq(irq));

/* File: tb.sv */
// Self-checking bench for the regeneration and learn-discard bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic pready, pslverr, frameValid = 0, queueValid, irq, engineEvent = 0;
    logic [1:0] framePort = 0, queueSel;
    logic [2:0] frameRxPrio = 0, regenPrio, learnDiscard = 0;
    int fails = 0, cmp_count = 0, cyc = 0;
    spr_regen_learn #(.ADDR_W(16)) DUT (.ref_clk(ref_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frameValid(frameValid), .framePort(framePort),
        .frameRxPrio(frameRxPrio), .queueValid(queueValid),
        .regenPrio(regenPrio), .queueSel(queueSel),
        .learnDiscard(learnDiscard), .engineEvent(engineEvent), .irq(irq));
    // Clock and hang guard
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, x);
        cmp_count++;
        if (s !== x)
        begin
            $display("mismatch %s exp %h seen %h", nm, x, s);
            fails++;
        end
    endtask
    // One APB transfer; waits for pready, holds everything until then
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [13:0] i, output logic [31:0] r);
        apb(0, {i, 2'b00}, 32'h0, r, er);
    endtask
    task automatic wr(input logic [13:0] i, input logic [31:0] d);
        apb(1, {i, 2'b00}, d, rv, er);
    endtask
    task automatic w2();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic frm(input logic [1:0] p, input logic [2:0] n, x);
        @(posedge ref_clk);
        frameValid <= 1;
        framePort <= p;
        frameRxPrio <= n;
        @(posedge ref_clk);
        frameValid <= 0;
        #1;
        chk("qv", 32'(queueValid), 32'(p != 2'h3));
        if (p != 2'h3)
        begin
            chk("prio", 32'(regenPrio), 32'(x));
            chk("qsel", 32'(queueSel), 32'(x[2:1]));
        end
    endtask
    task automatic t_reset();
        for (int p = 0; p < 3; p++)
        begin
            rd(spr_pkg::IDX_TBL0 + 14'(p), rv);
            chk("tbl", rv, 32'h00fac688);
            rd(spr_pkg::IDX_CNT0 + 14'(p), rv);
            chk("cnt", rv, 32'h0);
        end
        rd(spr_pkg::IDX_GMASK, rv);
        chk("gmask", rv, 32'h1);
        apb(0, 16'h0000, 32'h0, rv, er);
        chk("unmapped", {rv[30:0], er}, 32'h1);
        apb(1, {spr_pkg::IDX_TBL0, 2'h2}, 32'h0, rv, er);
        chk("misalign", 32'(er), 32'h1);
        rd(spr_pkg::IDX_TBL0, rv);
        chk("tblkept", rv, 32'h00fac688);
        $display("test reset done");
    endtask
    task automatic t_tbl();
        logic [23:0] w;
        for (int p = 0; p < 3; p++)
        begin
            for (int n = 0; n < 8; n++)
                w[3*n +: 3] = 3'(n + p + 1);
            wr(spr_pkg::IDX_TBL0 + 14'(p), {8'hff, w});
            rd(spr_pkg::IDX_TBL0 + 14'(p), rv);
            chk("tblrw", rv, {8'h00, w});
        end
        for (int p = 0; p < 3; p++)
            for (int n = 0; n < 8; n++)
                frm(2'(p), 3'(n), 3'(n + p + 1));
        frm(2'h3, 3'h0, 3'h0);
        $display("test table done");
    endtask
    task automatic t_cnt();
        for (int p = 0; p < 3; p++)
            repeat (p + 2)
            begin
                @(posedge ref_clk);
                learnDiscard <= 3'(1 << p);
                @(posedge ref_clk);
                learnDiscard <= 0;
            end
        for (int p = 0; p < 3; p++)
        begin
            rd(spr_pkg::IDX_CNT0 + 14'(p), rv);
            chk("cnt", rv, 32'(p + 2));
            rd(spr_pkg::IDX_CNT0 + 14'(p), rv);
            chk("rc", rv, 32'h0);
        end
        // Event lands on the decide edge of a clearing read
        fork
            rd(spr_pkg::IDX_CNT0, rv);
            begin
                repeat (2) @(posedge ref_clk);
                learnDiscard <= 3'h1;
                @(posedge ref_clk);
                learnDiscard <= 0;
            end
        join
        rd(spr_pkg::IDX_CNT0, rv);
        chk("clrhit", rv, 32'h1);
        $display("test count done");
    endtask
    task automatic t_irq();
        rd(spr_pkg::IDX_PEND, rv);
        chk("pend", rv, 32'h7);
        @(posedge ref_clk);
        engineEvent <= 1;
        @(posedge ref_clk);
        engineEvent <= 0;
        w2();
        chk("masked", 32'(irq), 32'h0);
        wr(spr_pkg::IDX_GMASK, 32'h0);
        w2();
        chk("unmask", 32'(irq), 32'h1);
        wr(spr_pkg::IDX_GMASK, 32'h1);
        w2();
        chk("remask", 32'(irq), 32'h0);
        wr(spr_pkg::IDX_GMASK, 32'h0);
        w2();
        chk("kept", 32'(irq), 32'h1);
        wr(spr_pkg::IDX_EVMASK, 32'h8);
        w2();
        chk("evmask", 32'(irq), 32'h0);
        wr(spr_pkg::IDX_EVMASK, 32'h0);
        rd(spr_pkg::IDX_PEND, rv);
        chk("pend", rv, 32'h8);
        w2();
        chk("cleared", 32'(irq), 32'h0);
        $display("test irq done");
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1;
        t_reset();
        t_tbl();
        t_cnt();
        t_irq();
        test_done();
    end
endmodule // tb
